// *** core/lnbc_pkg.sv ***
package lnbc_pkg;
    // APB map of the controller
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam int CMD_GO_BIT = 11;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_NACK_BIT = 2;
    localparam int STAT_RDATA_LSB = 8;
    // Serial timing
    localparam int CLK_NS = 5;
    localparam int BIT_NS = 2500;
    localparam int QTR_CYC = BIT_NS / 4 / CLK_NS;
    localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Device map
    localparam logic [4:0] DEV_ADDR_HI = 5'h02;
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_TONE = 3'h1;
    localparam logic [2:0] SEL_LIMIT = 3'h2;
    localparam logic [2:0] SEL_OUTPUT = 3'h3;
    localparam logic [4:0] KEEP_STATUS = 5'h00;
    localparam logic [4:0] KEEP_TONE = 5'h1c;
    localparam logic [4:0] KEEP_LIMIT = 5'h0f;
    localparam logic [4:0] KEEP_OUTPUT = 5'h1b;

    typedef struct packed {
        logic read;
        logic [1:0] addr_sel;
        logic [7:0] data;
    } lnbc_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STA = 2'b01,
        ST_BITS = 2'b10,
        ST_STO = 2'b11
    } lnbc_state_t;
endpackage

// *** core/lnbc_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bit rates up to 100 or 400 kbit/s, one clock pulse per bit.
// - Data changes only while clock is low, except start and stop.
// - Master sends a stop before every new start; no repeated starts.
// - Bytes are 8 bits, most significant first, each followed by acknowledge.
// - Master releases data during acknowledge; receiver holds it low throughout.
// - Device acknowledges each byte; on no acknowledge master may stop.
// - Master may skip acknowledge check by waiting one clock.
// - Address byte is 00010, two pin bits, then read-high direction bit.
// - Write is start, address with write, acknowledged data, then stop.
// - Master writes zero to every reserved bit.
// - Read shifts bytes out; master acknowledge asks for more, none ends.
module lnbc_master
    import lnbc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import lnbc_pkg::*;

    function automatic logic [4:0] keep_bits(input logic [2:0] sel);
        unique case (sel)
            SEL_TONE: keep_bits = KEEP_TONE;
            SEL_LIMIT: keep_bits = KEEP_LIMIT;
            SEL_OUTPUT: keep_bits = KEEP_OUTPUT;
            default: keep_bits = KEEP_STATUS;
        endcase
    endfunction

    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic scl_s, sda_s;
    lnbc_state_t state_reg, state_next;
    logic [1:0] phase_reg, phase_next;
    logic [6:0] tick_reg, tick_next;
    logic [3:0] bitn_reg, bitn_next;
    logic byte1_reg, byte1_next;
    logic [7:0] shreg_reg, shreg_next;
    logic [7:0] rdata_reg, rdata_next;
    lnbc_cmd_t cmd_reg, cmd_next;
    logic done_reg, done_next, nack_reg, nack_next;
    logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic wr_cmd, wr_stat, tick_done, tx, mapped;

    // Two-stage synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
        end
    end
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];

    assign mapped = (paddr == OFS_CMD) || (paddr == OFS_STAT);
    assign wr_cmd = psel && penable && pready_reg && pwrite
        && (paddr == OFS_CMD);
    assign wr_stat = psel && penable && pready_reg && pwrite
        && (paddr == OFS_STAT);
    assign tick_done = (tick_reg == QTR_LAST);
    assign tx = !byte1_reg || !cmd_reg.read;

    // APB slave: one wait-free access phase
    always_comb begin
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !mapped;
        prdata_next = 32'h0;
        if (psel && !penable && paddr == OFS_STAT) begin
            prdata_next[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
            prdata_next[STAT_DONE_BIT] = done_reg;
            prdata_next[STAT_NACK_BIT] = nack_reg;
            prdata_next[STAT_RDATA_LSB +: 8] = rdata_reg;
        end
    end

    // Serial sequencer
    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        bitn_next = bitn_reg;
        byte1_next = byte1_reg;
        shreg_next = shreg_reg;
        rdata_next = rdata_reg;
        cmd_next = cmd_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        done_next = done_reg && !(wr_stat && pwdata[STAT_DONE_BIT]);
        nack_next = nack_reg && !(wr_stat && pwdata[STAT_NACK_BIT]);
        tick_next = tick_done ? 7'h0 : tick_reg + 7'h1;
        // Wait in phase 2 while the clock line is held low by anyone
        if (phase_reg == 2'h2 && !scl_s && state_reg != ST_IDLE) begin
            tick_next = 7'h0;
        end
        unique case (state_reg)
            ST_IDLE: begin
                tick_next = 7'h0;
                phase_next = 2'h0;
                if (wr_cmd && pwdata[CMD_GO_BIT]) begin
                    cmd_next = lnbc_cmd_t'(pwdata[10:0]);
                    shreg_next = {DEV_ADDR_HI, pwdata[9:8], pwdata[10]};
                    bitn_next = 4'h0;
                    byte1_next = 1'b0;
                    state_next = ST_STA;
                end
            end
            ST_STA: begin
                if (tick_done && scl_s) begin
                    phase_next = phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_oe_next = 1'b1;
                    end else begin
                        scl_oe_next = 1'b1;
                        phase_next = 2'h0;
                        state_next = ST_BITS;
                    end
                end
            end
            ST_BITS: begin
                if (tick_done) begin
                    phase_next = phase_reg + 2'h1;
                    unique case (phase_reg)
                        2'h0: sda_oe_next = (bitn_reg != BIT_ACK) && tx
                            && !shreg_reg[7];
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: begin
                            if (bitn_reg != BIT_ACK) begin
                                shreg_next = {shreg_reg[6:0], sda_s};
                            end else if (tx && sda_s) begin
                                nack_next = 1'b1;
                            end
                        end
                        2'h3: begin
                            scl_oe_next = 1'b1;
                            bitn_next = bitn_reg + 4'h1;
                            if (bitn_reg == BIT_ACK) begin
                                bitn_next = 4'h0;
                                if (byte1_reg || nack_reg) begin
                                    state_next = ST_STO;
                                end else begin
                                    byte1_next = 1'b1;
                                    shreg_next = {cmd_reg.data[7:5],
                                        cmd_reg.data[4:0]
                                        & keep_bits(cmd_reg.data[7:5])};
                                end
                            end
                        end
                    endcase
                end
            end
            ST_STO: begin
                if (tick_done) begin
                    phase_next = phase_reg + 2'h1;
                    unique case (phase_reg)
                        2'h0: sda_oe_next = 1'b1;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b0;
                        2'h3: begin
                            state_next = ST_IDLE;
                            done_next = 1'b1;
                            if (cmd_reg.read && !nack_reg) begin
                                rdata_next = shreg_reg;
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            phase_reg <= 2'h0;
            tick_reg <= 7'h0;
            bitn_reg <= 4'h0;
            byte1_reg <= 1'b0;
            shreg_reg <= 8'h0;
            rdata_reg <= 8'h0;
            cmd_reg <= '0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            tick_reg <= tick_next;
            bitn_reg <= bitn_next;
            byte1_reg <= byte1_next;
            shreg_reg <= shreg_next;
            rdata_reg <= rdata_next;
            cmd_reg <= cmd_next;
            done_reg <= done_next;
            nack_reg <= nack_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_cond_a: assert property (
        $rose(sda_oe_reg) && !scl_oe_reg |-> state_reg == ST_STA
    ) else $error("data pulled low with clock high outside start");
    sda_stable_a: assert property (
        state_reg == ST_BITS && phase_reg[1] && $past(phase_reg[1])
        |-> $stable(sda_oe_reg)
    ) else $error("data moved while clock high");
    stop_first_a: assert property (
        state_reg == ST_IDLE && $past(state_reg) != ST_IDLE
        |-> $past(state_reg) == ST_STO && !sda_oe_reg && !scl_oe_reg
    ) else $error("transfer ended without stop");
    ack_release_a: assert property (
        state_reg == ST_BITS && bitn_reg == BIT_ACK && phase_reg != 2'h0
        |-> !sda_oe_reg
    ) else $error("master drove data during acknowledge");
    byte_len_a: assert property (
        state_reg == ST_BITS && $past(state_reg) == ST_BITS
        && bitn_reg != $past(bitn_reg)
        |-> bitn_reg == $past(bitn_reg) + 4'h1
        || ($past(bitn_reg) == BIT_ACK && bitn_reg == 4'h0)
    ) else $error("bit count skipped");
    clk_low_a: assert property (
        $rose(scl_oe_reg) |=> scl_oe_reg [*8]
    ) else $error("clock low phase too short");
    nack_stop_a: assert property (
        state_reg == ST_BITS && bitn_reg == BIT_ACK && phase_reg == 2'h2
        && tick_done && tx && sda_s
        |=> nack_reg ##[1:200] state_reg == ST_STO
    ) else $error("missing acknowledge not followed by stop");
    addr_byte_a: assert property (
        state_reg == ST_STA ##1 state_reg == ST_BITS
        |-> shreg_reg[7:3] == DEV_ADDR_HI && shreg_reg[0] == cmd_reg.read
    ) else $error("bad address byte");
    resv_zero_a: assert property (
        state_reg == ST_BITS && byte1_reg && bitn_reg == 4'h0
        && phase_reg == 2'h0 && !cmd_reg.read
        |-> (shreg_reg[4:0] & ~keep_bits(shreg_reg[7:5])) == 5'h0
    ) else $error("reserved bit sent as one");
    apb_ready_a: assert property (
        psel && !penable |=> pready_reg
    ) else $error("no ready in access phase");

    wr_done_c: cover property (
        $rose(done_reg) && !cmd_reg.read && !nack_reg);
    rd_done_c: cover property (
        $rose(done_reg) && cmd_reg.read && !nack_reg);
    nack_c: cover property ($rose(nack_reg));
endmodule
`default_nettype wire

// *** sim/lnbc_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lnbc_dev_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic power_ok,
    input wire logic slow,
    input wire logic [1:0] addr_pins,
    input wire logic [4:0] flags,
    output logic sda_oe,
    output logic scl_oe
);
    // Index 0 fault_status, 1 tone_setup, 2 limit_command, 3 output_control
    logic [7:0] sys_reg [0:3];
    logic [7:0] sh;
    logic hit;
    logic in_frame = 0;
    int start_cnt = 0;
    int restart_cnt = 0;
    initial begin
        sda_oe = 0;
        scl_oe = 0;
        foreach (sys_reg[i]) sys_reg[i] = 8'h00;
    end
    always @(negedge power_ok) foreach (sys_reg[i]) sys_reg[i] = 8'h00;
    task automatic get_byte();
        repeat (8) @(posedge scl) sh = {sh[6:0], sda};
    endtask
    task automatic ack_bit(input logic a);
        @(negedge scl) sda_oe = a;
        if (a && slow) begin
            scl_oe = 1;
            #2000 scl_oe = 0;
        end
        @(negedge scl) sda_oe = 0;
    endtask
    always @(negedge sda) if (scl === 1'b1) begin
        start_cnt++;
        if (in_frame) restart_cnt++;
        in_frame = 1;
    end
    always begin : frame
        @(negedge sda iff scl === 1'b1);
        get_byte();
        hit = power_ok && sh[7:1] == {5'h02, addr_pins};
        ack_bit(hit);
        if (hit && !sh[0]) begin
            forever begin
                get_byte();
                if (sh[7:5] inside {[1:3]}) sys_reg[sh[6:5]] = sh;
                ack_bit(1'b1);
            end
        end else if (hit) begin
            sh = {sys_reg[0][7:5], flags};
            do begin
                for (int i = 7; i >= 0; i--) begin
                    sda_oe = !sh[i];
                    @(negedge scl);
                end
                sda_oe = 0;
                @(posedge scl) hit = !sda;
                @(negedge scl);
            end while (hit);
        end
        @(posedge sda iff scl === 1'b1);
    end
    always @(posedge sda) if (scl === 1'b1) begin
        disable frame;
        sda_oe = 0;
        scl_oe = 0;
        in_frame = 0;
    end
endmodule
`default_nettype wire

// *** sim/lnbc_master_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module lnbc_master_bench;
    import lnbc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, er, power_ok, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, m_sda, m_scl;
    logic [1:0] pins;
    logic [4:0] flags;
    int fails = 0;
    int check_count = 0;
    wire scl_w;
    wire sda_w;
    assign scl_w = !(scl_oe || m_scl);
    assign sda_w = !(sda_oe || m_sda);
    lnbc_master dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe));
    lnbc_dev_model mdl (.scl(scl_w), .sda(sda_w), .power_ok(power_ok),
        .slow(slow), .addr_pins(pins), .flags(flags), .sda_oe(m_sda),
        .scl_oe(m_scl));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic go(input logic r, input logic [1:0] ap,
                      input logic [7:0] d);
        apb(1, OFS_CMD, {20'h0, 1'b1, r, ap, d}, rd);
    endtask
    task automatic wait_done(output logic [31:0] st);
        int n = 0;
        do apb(0, OFS_STAT, 0, st);
        while (st[STAT_DONE_BIT] !== 1'b1 && ++n < 9000);
        if (n >= 9000) begin
            fails++;
            print_verdict();
        end
        apb(1, OFS_STAT, 32'h6, rd);
    endtask
    function automatic logic [7:0] stored(input logic [7:0] d);
        case (d[7:5])
            SEL_TONE: return {d[7:5], d[4:0] & KEEP_TONE};
            SEL_LIMIT: return {d[7:5], d[4:0] & KEEP_LIMIT};
            default: return {d[7:5], d[4:0] & KEEP_OUTPUT};
        endcase
    endfunction
    initial begin
        pclk = 0;
        forever #2.5 pclk = !pclk;
    end
    initial begin
        #450_000;
        fails++;
        print_verdict();
    end
    initial begin
        logic [7:0] d;
        logic [7:0] d1;
        logic [31:0] st;
        int n0;
        {presetn, psel, penable, pwrite, slow, pins, flags} = 0;
        paddr = 0;
        pwdata = 0;
        power_ok = 1;
        void'($urandom(32'hd44e));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) check(mdl.sys_reg[i], 0);
        apb(0, OFS_STAT, 0, rd);
        check(rd, 0);
        apb(0, 8'h08, 0, rd);
        check(rd, 0);
        check(er, 1);
        d1 = 8'h00;
        for (int s = 0; s < 4; s++) begin
            pins <= 2'(s);
            d = {3'(s), 5'($urandom | 32'h17)};
            if (s == 1) d1 = d;
            n0 = mdl.start_cnt;
            go(0, 2'(s), d);
            go(0, 2'(s), ~d);
            wait_done(st);
            check(st[2:0], 3'b010);
            check(mdl.start_cnt - n0, 1);
            if (s == 0) check(mdl.sys_reg[0], 0);
            else check(mdl.sys_reg[s], stored(d));
        end
        flags <= 5'($urandom);
        slow <= 1;
        go(1, 2'd3, 8'h00);
        wait_done(st);
        check(st[15:0], {3'h0, flags, 8'h02});
        apb(0, OFS_STAT, 0, rd);
        check(rd[2:0], 0);
        go(0, 2'd0, 8'h3f);
        wait_done(st);
        check(st[2:0], 3'b110);
        check(mdl.sys_reg[1], stored(d1));
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, OFS_STAT, 0, rd);
        check(rd, 0);
        power_ok <= 0;
        @(posedge pclk);
        check(mdl.sys_reg[3], 0);
        go(0, 2'd3, 8'h7f);
        wait_done(st);
        check(st[2:0], 3'b110);
        check(mdl.sys_reg[3], 0);
        check({scl_o, sda_o}, 0);
        check(mdl.restart_cnt, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
